// ===== core/sd_decim.sv
// One sigma-delta decimator: boxcar count of ones over a fixed window.
// Runs on the modulator clock; bit arrives with that clock.
`timescale 1ns/100ps
`default_nettype none
module sd_decim (
  input  wire logic                              mod_clk,  // Modulator clock
  input  wire logic                              mod_rst,  // Synced reset
  input  wire logic                              bit_in,   // Sensor bit
  output logic [thermo_pkg::SAMPLE_W-1:0]        word_r,   // Window sum
  output logic                                   tgl_r     // Flips per word
);

  logic [thermo_pkg::DEC_LOG-1:0]  pos_r;
  logic [thermo_pkg::SAMPLE_W-1:0] acc_r;

  // ==========================================================
  // Window accumulate and hand off
  always_ff @(posedge mod_clk) begin
    if (mod_rst) begin
      pos_r  <= '0;
      acc_r  <= '0;
      word_r <= '0;
      tgl_r  <= 1'b0;
    end else begin
      pos_r <= pos_r + 1'b1;
      if (&pos_r) begin
        word_r <= acc_r + {{(thermo_pkg::SAMPLE_W-1){1'b0}}, bit_in};
        acc_r  <= '0;
        tgl_r  <= ~tgl_r;
      end else begin
        acc_r <= acc_r + {{(thermo_pkg::SAMPLE_W-1){1'b0}}, bit_in};
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/thermo_out_ctrl.sv
// Measurement sequencer, duty-cycle output and shared pin control.
// Sensor bits, their reset sync and decimators run on the modulator clock; the rest runs on core_clk.
`timescale 1ns/100ps
`default_nettype none
module thermo_out_ctrl #(
  parameter int PWM_PERIOD_CYC = thermo_pkg::PWM_PERIOD_CYC,
  parameter int REQ_CYC        = thermo_pkg::REQ_CYC,
  parameter int WAKE_CYC       = thermo_pkg::WAKE_CYC,
  parameter int TIMEOUT_CYC    = thermo_pkg::TIMEOUT_CYC
) (
  input  wire logic                   core_clk,    // Core clock
  input  wire logic                   rst,         // Power-on reset
  input  wire logic                   mod_clk,     // Modulator clock
  input  wire logic                   amb_bit,     // Ambient bit stream
  input  wire logic [1:0]             ir_bits,     // IR bit streams
  input  wire thermo_pkg::cfg_t       cfg,         // Nonvolatile config
  input  wire logic                   scl_in,      // Serial clock pin
  input  wire logic                   pin_in,      // Shared pin level
  output logic                        pin_out,     // Shared pin drive
  output logic                        pin_oe,      // Shared pin enable
  output thermo_pkg::ram_cells_t      ram_cells,   // Result cells
  output logic                        smbus_mode,  // Pin in two-wire use
  output logic                        bus_active,  // Transfer in flight
  output logic                        wake         // Wake request pulse
);

  localparam int STEP_CYC = PWM_PERIOD_CYC / thermo_pkg::PWM_SLOTS;
  localparam logic [thermo_pkg::STEP_W-1:0] STEP_LAST =
    thermo_pkg::STEP_W'(STEP_CYC - 1);

  // ==========================================================
  // Modulator domain: reset sync and decimators
  logic                                    mrst_s1;
  logic                                    mrst_r;
  logic [thermo_pkg::NCH-1:0]              bits;
  logic [thermo_pkg::NCH-1:0][thermo_pkg::SAMPLE_W-1:0] words;
  logic                                    word_tgl;
  logic                                    mrst_req_r;
  logic                                    mrst_d_r;
  logic                                    mack_s1;
  logic                                    mack_r;

  assign bits = {ir_bits, amb_bit};

  always_ff @(posedge mod_clk) begin
    mrst_s1  <= mrst_req_r;
    mrst_r   <= mrst_s1;
    mrst_d_r <= mrst_r;
  end

  // Short reset would miss the slow clock: hold until echoed back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mrst_req_r <= 1'b1;
      mack_s1    <= 1'b0;
      mack_r     <= 1'b0;
    end else begin
      mack_s1 <= mrst_d_r;
      mack_r  <= mack_s1;
      if (mack_r) begin
        mrst_req_r <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < thermo_pkg::NCH; i++) begin : g_ch
    if (i == 0) begin : g_lead
      sd_decim u_dec (
        .mod_clk (mod_clk),
        .mod_rst (mrst_r),
        .bit_in  (bits[i]),
        .word_r  (words[i]),
        .tgl_r   (word_tgl)
      );
    end else begin : g_rest
      sd_decim u_dec (
        .mod_clk (mod_clk),
        .mod_rst (mrst_r),
        .bit_in  (bits[i]),
        .word_r  (words[i]),
        .tgl_r   ()
      );
    end
  end

  // ==========================================================
  // Crossing: toggle sync, words stable for a whole window
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  logic new_sample;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= word_tgl & ~mrst_req_r;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end
  assign new_sample = tg_s2 ^ tg_s3;

  // ==========================================================
  // Configuration captured after reset release
  thermo_pkg::cfg_t cfg_r;
  logic             cfg_taken_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_r       <= '0;
      cfg_taken_r <= 1'b0;
    end else if (!cfg_taken_r) begin
      cfg_r       <= cfg;
      cfg_taken_r <= 1'b1;
    end
  end

  // ==========================================================
  // Sequencer
  thermo_pkg::seq_state_t st_r;
  thermo_pkg::seq_state_t st_nxt;

  always_comb begin
    case (st_r)
      thermo_pkg::ST_IDLE:  st_nxt = new_sample && cfg_taken_r ?
                                     thermo_pkg::ST_FILT : thermo_pkg::ST_IDLE;
      thermo_pkg::ST_FILT:  st_nxt = thermo_pkg::ST_CALC;
      thermo_pkg::ST_CALC:  st_nxt = thermo_pkg::ST_SCALE;
      thermo_pkg::ST_SCALE: st_nxt = thermo_pkg::ST_LOAD;
      thermo_pkg::ST_LOAD:  st_nxt = thermo_pkg::ST_IDLE;
      default:              st_nxt = thermo_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= thermo_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // IIR filter per channel
  logic [thermo_pkg::NCH-1:0][15:0] filt_r;

  for (genvar i = 0; i < thermo_pkg::NCH; i++) begin : g_iir
    logic signed [16:0] diff;
    assign diff = $signed({1'b0, words[i], {thermo_pkg::SAMPLE_SHIFT{1'b0}}})
                - $signed({1'b0, filt_r[i]});
    always_ff @(posedge core_clk) begin
      if (rst) begin
        filt_r[i] <= '0;
      end else if (st_r == thermo_pkg::ST_FILT) begin
        filt_r[i] <= filt_r[i]
                   + 16'(diff >>> cfg_r.iir_shift);
      end
    end
  end

  // ==========================================================
  // Temperatures in 0.01 C, cells in 0.02 C
  logic signed [15:0] ambient_temp_r;
  logic signed [15:0] object_temp_r;
  logic signed [15:0] object_temp2_r;
  logic signed [15:0] ir1_delta;
  logic signed [15:0] ir2_delta;

  assign ir1_delta = $signed(filt_r[thermo_pkg::CH_IR1] - thermo_pkg::IR_MID)
                     >>> thermo_pkg::IR_GAIN_SHR;
  assign ir2_delta = $signed(filt_r[thermo_pkg::CH_IR2] - thermo_pkg::IR_MID)
                     >>> thermo_pkg::IR_GAIN_SHR;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ambient_temp_r <= '0;
      object_temp_r  <= '0;
      object_temp2_r <= '0;
    end else if (st_r == thermo_pkg::ST_CALC) begin
      ambient_temp_r <= $signed(filt_r[thermo_pkg::CH_AMB]
                                - thermo_pkg::AMB_OFS);
      object_temp_r  <= $signed(filt_r[thermo_pkg::CH_AMB]
                                - thermo_pkg::AMB_OFS) + ir1_delta;
      object_temp2_r <= cfg_r.dual_zone ?
                        $signed(filt_r[thermo_pkg::CH_AMB]
                                - thermo_pkg::AMB_OFS) + ir2_delta
                        : 16'sh0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ram_cells <= '0;
    end else if (st_r == thermo_pkg::ST_SCALE) begin
      ram_cells.amb  <= 16'(ambient_temp_r >>> 1);
      ram_cells.obj1 <= 16'(object_temp_r >>> 1);
      ram_cells.obj2 <= 16'(object_temp2_r >>> 1);
    end
  end

  // ==========================================================
  // Rescale to 10 bits and load output registers
  logic signed [16:0] above_min;
  logic signed [16:0] scaled;
  logic [9:0]         pwm_new;
  logic [9:0]         pwm_pend_r;
  logic               pend_valid_r;

  assign above_min = 17'(object_temp_r) - 17'(cfg_r.tmin);
  assign scaled    = above_min >>> cfg_r.scale_shift;
  assign pwm_new   = scaled < 0 ? 10'h000 :
                     scaled > $signed({7'h00, thermo_pkg::PWM_MAX}) ?
                     thermo_pkg::PWM_MAX : scaled[9:0];

  logic period_end;
  logic [thermo_pkg::STEP_W-1:0] step_r;
  logic [9:0]                    slot_r;
  logic [9:0]                    duty_r;
  logic                          pwm_level_r;

  assign period_end = (step_r == STEP_LAST) && (slot_r == thermo_pkg::PWM_MAX);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_pend_r   <= '0;
      pend_valid_r <= 1'b0;
    end else if (st_r == thermo_pkg::ST_LOAD) begin
      pwm_pend_r   <= pwm_new;
      pend_valid_r <= 1'b1;
    end else if (period_end) begin
      pend_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Duty-cycle generator: 1024 slots of STEP_CYC cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_r      <= '0;
      slot_r      <= '0;
      duty_r      <= '0;
      pwm_level_r <= 1'b0;
    end else begin
      if (step_r == STEP_LAST) begin
        step_r <= '0;
        slot_r <= slot_r + 1'b1;
      end else begin
        step_r <= step_r + 1'b1;
      end
      if (period_end && pend_valid_r) begin
        duty_r <= pwm_pend_r;
      end
      pwm_level_r <= slot_r < duty_r;
    end
  end

  // ==========================================================
  // Serial pins: sync, start/stop, low timers
  logic scl_s1;
  logic scl_r;
  logic sda_s1;
  logic sda_r;
  logic sda_d_r;
  logic [thermo_pkg::CNT_W-1:0] scl_low_r;
  logic [thermo_pkg::CNT_W-1:0] sda_low_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1  <= 1'b1;
      scl_r   <= 1'b1;
      sda_s1  <= 1'b1;
      sda_r   <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1  <= scl_in;
      scl_r   <= scl_s1;
      sda_s1  <= pin_in;
      sda_r   <= sda_s1;
      sda_d_r <= sda_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || scl_r) begin
      scl_low_r <= '0;
    end else if (scl_low_r != '1) begin
      scl_low_r <= scl_low_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || sda_r) begin
      sda_low_r <= '0;
    end else if (sda_low_r != '1) begin
      sda_low_r <= sda_low_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_active <= 1'b0;
    end else if (scl_low_r == thermo_pkg::CNT_W'(TIMEOUT_CYC - 1)
                 && !scl_r) begin
      bus_active <= 1'b0;
    end else if (smbus_mode && scl_r && sda_d_r && !sda_r) begin
      bus_active <= 1'b1;
    end else if (scl_r && !sda_d_r && sda_r) begin
      bus_active <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      smbus_mode <= 1'b0;
    end else if (!cfg_taken_r) begin
      smbus_mode <= !cfg.pwm_en;
    end else if (scl_low_r == thermo_pkg::CNT_W'(REQ_CYC - 1) && !scl_r) begin
      smbus_mode <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= (sda_low_r == thermo_pkg::CNT_W'(WAKE_CYC - 1)) && !sda_r;
    end
  end

  // ==========================================================
  // Shared pin drive
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b1;
    end else if (smbus_mode || !cfg_taken_r) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= pwm_level_r;
      pin_oe  <= cfg_r.push_pull | ~pwm_level_r;
    end
  end

  // ==========================================================
  // Checks
  AST_SEQ_ORDER: assert property (@(posedge core_clk) disable iff (rst)
    st_r == thermo_pkg::ST_FILT |=> st_r == thermo_pkg::ST_CALC ##1
    st_r == thermo_pkg::ST_SCALE ##1 st_r == thermo_pkg::ST_LOAD)
    else $error("sequencer skipped a step");

  AST_CELL_HALF: assert property (@(posedge core_clk) disable iff (rst)
    st_r == thermo_pkg::ST_SCALE |=>
    ram_cells.amb == 16'($past(ambient_temp_r) >>> 1))
    else $error("ambient cell not half of ambient temperature");

  AST_SINGLE_ZONE: assert property (@(posedge core_clk) disable iff (rst)
    st_r == thermo_pkg::ST_SCALE && !cfg_r.dual_zone |=>
    ram_cells.obj2 == 16'h0000)
    else $error("second zone cell written in single zone");

  AST_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    st_r == thermo_pkg::ST_LOAD |=> pend_valid_r &&
    pwm_pend_r == $past(pwm_new))
    else $error("rescaled value not loaded");

  AST_DUTY: assert property (@(posedge core_clk) disable iff (rst)
    pwm_level_r == ($past(slot_r) < $past(duty_r)))
    else $error("output level does not match duty");

  AST_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
    period_end |=> slot_r == 10'h000 && step_r == '0)
    else $error("output period did not wrap");

  AST_POR_PIN: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> pin_oe && !pin_out)
    else $error("pin not pulled low during reset");

  AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (rst)
    !scl_r && scl_low_r == thermo_pkg::CNT_W'(TIMEOUT_CYC - 1) |=>
    !bus_active)
    else $error("transfer kept after clock low timeout");

endmodule
`default_nettype wire

// ===== core/thermo_pkg.sv
// Shared constants and carrier types for the thermometer output controller.
// Assumes a 250 MHz core clock and a free-running modulator clock.
package thermo_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int PWM_PERIOD_NS  = 1024000;   // 1.024 ms
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REQ_US         = 1440;      // 1.44 ms
  localparam int REQ_CYC        = (REQ_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int WAKE_US        = 33000;     // 33 ms
  localparam int WAKE_CYC       = (WAKE_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int TIMEOUT_US     = 27000;     // 27 ms, low end of window
  localparam int TIMEOUT_CYC    = (TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CNT_W          = 24;

  // ==========================================================
  // Output resolution
  localparam int PWM_RES_BITS   = 10;
  localparam int PWM_SLOTS      = 1024;
  localparam int STEP_W         = 16;

  // ==========================================================
  // Channels and arithmetic
  localparam int NCH            = 3;
  localparam int CH_AMB         = 0;
  localparam int CH_IR1         = 1;
  localparam int CH_IR2         = 2;
  localparam int DEC_LOG        = 10;
  localparam int SAMPLE_W       = DEC_LOG + 1;
  localparam int TEMP_W         = 16;
  localparam int SAMPLE_SHIFT   = TEMP_W - SAMPLE_W;
  localparam logic [15:0] AMB_OFS      = 16'h2000;
  localparam logic [15:0] IR_MID       = 16'h8000;
  localparam int          IR_GAIN_SHR  = 2;
  localparam logic [9:0]  PWM_MAX      = 10'h3FF;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              pwm_en;       // Pin starts as duty-cycle output
    logic              push_pull;    // Duty-cycle drive style
    logic              dual_zone;    // Second IR channel fitted
    logic [1:0]        iir_shift;    // IIR weight 1/2^n
    logic signed [15:0] tmin;        // Duty range low end, 0.01 C
    logic [3:0]        scale_shift;  // Duty range width as shift
  } cfg_t;

  typedef struct packed {
    logic [15:0] amb;
    logic [15:0] obj1;
    logic [15:0] obj2;
  } ram_cells_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FILT  = 5'h02,
    ST_CALC  = 5'h04,
    ST_SCALE = 5'h08,
    ST_LOAD  = 5'h10
  } seq_state_t;

endpackage

// ===== testbench/ir_thermometer_output_ctrl_tb.sv
// Self-checking bench for the thermometer output controller.
// Assumes the two-wire master model and shortened timing parameters.
`timescale 1ns/100ps
`default_nettype none
module ir_thermometer_output_ctrl_tb;
  localparam int PWM_CYC = 4096;
  localparam int REQ     = 40;
  localparam int WAKE    = 100;
  localparam int TMO     = 200;
  localparam int CEIL    = 80000;

  logic                   core_clk = 1'b0;
  logic                   mod_clk  = 1'b0;
  logic                   rst      = 1'b1;
  logic                   amb_bit  = 1'b1;
  logic [1:0]             ir_bits  = 2'h0;
  logic [1:0]             ph       = 2'h0;
  thermo_pkg::cfg_t       cfg      = '0;
  logic                   scl_in;
  logic                   pin_in;
  logic                   pin_out;
  logic                   pin_oe;
  logic                   smbus_mode;
  logic                   bus_active;
  logic                   wake;
  thermo_pkg::ram_cells_t ram_cells;
  int                     hi_cyc;
  int                     per_cyc;
  int                     n_fail = 0;
  int                     checks = 0;
  int                     cyc    = 0;
  int                     n_wake = 0;
  int                     seed   = 32'h5DB2;
  int                     d;
  int                     amb;
  int                     obj;
  int                     w0;
  int                     i;

  thermo_out_ctrl #(
    .PWM_PERIOD_CYC (PWM_CYC),
    .REQ_CYC        (REQ),
    .WAKE_CYC       (WAKE),
    .TIMEOUT_CYC    (TMO)
  ) dut_u (
    .core_clk   (core_clk),
    .rst        (rst),
    .mod_clk    (mod_clk),
    .amb_bit    (amb_bit),
    .ir_bits    (ir_bits),
    .cfg        (cfg),
    .scl_in     (scl_in),
    .pin_in     (pin_in),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .ram_cells  (ram_cells),
    .smbus_mode (smbus_mode),
    .bus_active (bus_active),
    .wake       (wake)
  );

  smbus_master_model partner_u (
    .core_clk (core_clk),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe),
    .scl_in   (scl_in),
    .pin_in   (pin_in),
    .hi_cyc   (hi_cyc),
    .per_cyc  (per_cyc)
  );

  // ==========================================================
  // Clocks and sensor streams
  always #2 core_clk = ~core_clk;
  initial begin
    #13;
    forever #80 mod_clk = ~mod_clk;
  end
  // Fixed counts per window: ambient 3 of 4 ones, zone 1 half
  always @(posedge mod_clk) begin
    ph         <= ph + 2'h1;
    amb_bit    <= ph != 2'h3;
    ir_bits[0] <= !ir_bits[0];
    ir_bits[1] <= 1'($random(seed));
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (cyc == CEIL) begin
      n_fail++;
      final_report;
    end
  end

  // ==========================================================
  // Expectations
  function automatic int amb_temp(input int ones);
    return (ones << 5) - int'(thermo_pkg::AMB_OFS);
  endfunction
  function automatic int obj_temp(input int a, input int ones);
    return a + (((ones << 5) - int'(thermo_pkg::IR_MID))
                >>> thermo_pkg::IR_GAIN_SHR);
  endfunction

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    d   = 1 + ({$random(seed)} % 1000);
    amb = amb_temp(768);
    obj = obj_temp(amb, 512);
    cfg.pwm_en      = 1'b1;
    cfg.push_pull   = 1'b1;
    cfg.tmin        = 16'(obj - 4 * d);
    cfg.scale_shift = 4'h2;
    tick(4);
    check("oe in reset", 48'h1, 48'(pin_oe));
    check("drive in reset", 48'h0, 48'(pin_out));
    check("cells in reset", 48'h0, ram_cells);
    @(posedge core_clk);
    rst <= 1'b0;
    tick(3);
    check("mode after reset", 48'h0, 48'(smbus_mode));
    partner_u.set_sda_low(1'b1);
    tick(2);
    check("start in duty mode", 48'h0, 48'(bus_active));
    partner_u.set_sda_low(1'b0);
    $display("test reset finished");

    for (i = 0; i < 60000 && ram_cells === '0; i++) tick(1);
    tick(2);
    check("ambient cell", 48'(16'(amb >>> 1)), 48'(ram_cells.amb));
    check("zone1 cell", 48'(16'(obj >>> 1)), 48'(ram_cells.obj1));
    check("zone2 cell", 48'h0, 48'(ram_cells.obj2));
    tick(3 * PWM_CYC);
    check("period", 48'(PWM_CYC), 48'(per_cyc));
    check("high time", 48'(d * (PWM_CYC / 1024)), 48'(hi_cyc));
    $display("test measure finished");

    partner_u.hold_scl(REQ - 6);
    tick(6);
    check("mode short hold", 48'h0, 48'(smbus_mode));
    partner_u.hold_scl(REQ + 4);
    tick(6);
    check("mode long hold", 48'h1, 48'(smbus_mode));
    check("pin released", 48'h0, 48'(pin_oe));
    partner_u.set_sda_low(1'b1);
    tick(2);
    check("start", 48'h1, 48'(bus_active));
    partner_u.set_sda_low(1'b0);
    tick(2);
    check("stop", 48'h0, 48'(bus_active));
    partner_u.set_sda_low(1'b1);
    partner_u.hold_scl(TMO - 10);
    tick(4);
    check("short clock low", 48'h1, 48'(bus_active));
    partner_u.hold_scl(TMO + 6);
    tick(4);
    check("clock low timeout", 48'h0, 48'(bus_active));
    partner_u.set_sda_low(1'b0);
    $display("test bus finished");

    w0 = n_wake;
    partner_u.hold_sda(WAKE - 6);
    tick(6);
    check("wake short", 48'h0, 48'(n_wake - w0));
    partner_u.hold_sda(WAKE + 6);
    tick(6);
    check("wake pulse", 48'h1, 48'(n_wake - w0));
    $display("test wake finished");

    @(posedge core_clk);
    rst        <= 1'b1;
    cfg.pwm_en <= 1'b0;
    tick(4);
    check("oe in second reset", 48'h1, 48'(pin_oe));
    check("mode in reset", 48'h0, 48'(smbus_mode));
    @(posedge core_clk);
    rst <= 1'b0;
    tick(3);
    check("configured bus mode", 48'h1, 48'(smbus_mode));
    $display("test second reset finished");
    final_report;
  end
endmodule
`default_nettype wire

// ===== testbench/smbus_master_model.sv
// Two-wire master and duty-cycle reader facing the shared pin.
// Assumes pulled-up clock and data lines and the device pin pair.
`timescale 1ns/100ps
`default_nettype none
module smbus_master_model (
  input  wire logic core_clk,  // Core clock
  input  wire logic pin_out,   // Device pin drive
  input  wire logic pin_oe,    // Device pin enable
  output var  logic scl_in,    // Clock line level
  output var  logic pin_in,    // Data line level
  output var  int   hi_cyc,    // Last high time
  output var  int   per_cyc    // Last period
);
  logic scl_low_r = 1'b0;
  logic sda_low_r = 1'b0;
  logic lvl_r     = 1'b0;
  int   hi_r      = 0;
  int   per_r     = 0;

  // ==========================================================
  // Wires: pull-up, low wins
  assign scl_in = !scl_low_r;
  assign pin_in = (pin_oe ? pin_out : 1'b1) & !sda_low_r;

  // ==========================================================
  // Duty reader, latched at each rising edge
  always @(posedge core_clk) begin
    lvl_r <= pin_in;
    if (pin_in && !lvl_r) begin
      hi_cyc  <= hi_r;
      per_cyc <= per_r;
      hi_r    <= 1;
      per_r   <= 1;
    end else begin
      hi_r  <= hi_r + int'(pin_in);
      per_r <= per_r + 1;
    end
  end

  // ==========================================================
  // Master line actions
  task automatic hold_scl(input int n);
    @(posedge core_clk);
    scl_low_r <= 1'b1;
    repeat (n) @(posedge core_clk);
    scl_low_r <= 1'b0;
  endtask

  task automatic hold_sda(input int n);
    @(posedge core_clk);
    sda_low_r <= 1'b1;
    repeat (n) @(posedge core_clk);
    sda_low_r <= 1'b0;
  endtask

  task automatic set_sda_low(input logic v);
    @(posedge core_clk);
    sda_low_r <= v;
    repeat (4) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire
